/* rtl/port_mux_map.vh */
// constants for the port multiplexer and bank select block
// assumes a wishbone byte-wide register window, one register per word
// Notes on behaviour
// (R1) only one bank select active per cycle
// (R2) eprom selects cover 8000h to ffffh
// (R3) ram selects cover 2000h to 3fffh
// (R4) peripheral select covers 10c0h to 10ffh
// (R5) chip selects only in microcomputer mode
// (R6) external memories need three-state outputs
// (R7) both controls zero, dir zero: input
// (R8) both controls zero, dir one: output
// (R9) control two set selects function a/b
// (R10) function one set, two clear: undefined
// (R11) d1 d2 d5 no bus function microprocessor
// (R12) port a control ffh: data bus
// (R13) port b control ffh: low address
// (R14) port c control 7fh: high address
// (R15) config one bit four clear: waits
// (R16) reset fetches from internal memory
// (R17) disabled select output drives its data bit
// (R18) board pulls up chip select pins
// (R19) d control bits 0,1,2 select banks
// (R20) disable eprom selects from internal code
// (R21) clear ram selects before enabling another
// (R22) valid instruction follows bank switch
// (R23) select low only in mapped bus cycle
`ifndef PORT_MUX_MAP_VH
`define PORT_MUX_MAP_VH
// register indices (byte address is four times)
`define IDX_A_CTL1    16'h1020
`define IDX_A_CTL2    16'h1021
`define IDX_A_VAL     16'h1022
`define IDX_A_DIR     16'h1023
`define IDX_B_CTL1    16'h1024
`define IDX_B_CTL2    16'h1025
`define IDX_B_VAL     16'h1026
`define IDX_B_DIR     16'h1027
`define IDX_C_CTL1    16'h1028
`define IDX_C_CTL2    16'h1029
`define IDX_C_VAL     16'h102a
`define IDX_C_DIR     16'h102b
`define IDX_D_FN1     16'h102c
`define IDX_D_FN2     16'h102d
`define IDX_D_VAL     16'h102e
`define IDX_D_DIR     16'h102f
`define IDX_SYS_CFG0  16'h1010
`define IDX_SYS_CFG1  16'h1011
// field positions
`define CFG1_WAIT_BIT 4
`define D_RAM2_BIT    0
`define D_EPROM3_BIT  1
`define D_EPROM2_BIT  2
`define D_PERIPH_BIT  5
`define D_EPROM1_BIT  6
`define D_RAM1_BIT    7
// reset values
`define RST_REG8      8'h00
// address windows
`define EPROM_LO      16'h8000
`define EPROM_HI      16'hffff
`define RAM_LO        16'h2000
`define RAM_HI        16'h3fff
`define PERIPH_LO     16'h10c0
`define PERIPH_HI     16'h10ff
`endif

/* rtl/port_mux_bank_select.v */
// port pin multiplexing and external bank chip selects
// four byte ports, control registers on a wishbone window
// assumes a classic wishbone master and a cpu bus cycle from the core
// assumes the mode input is already settled in this clock domain
//
// Chosen here: register access over Wishbone.
`include "port_mux_map.vh"

module port_mux_bank_select (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        rstn_i,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [15:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // core external bus cycle
  input  wire        ext_cycle_i,
  input  wire        ext_write_i,
  input  wire [15:0] ext_addr_i,
  input  wire [7:0]  ext_wdata_i,
  input  wire        clkout_i,
  input  wire        micro_proc_mode_i,
  // pins of ports a to d
  input  wire [31:0] pin_in_i,
  output reg  [31:0] pin_out_o,
  output reg  [31:0] pin_oe_o,
  // to the core
  output reg  [7:0]  ext_rdata_o,
  output reg         wait_enable_o,
  output reg         boot_internal_o
);

  // ==========================================================
  // registers
  // ports a to c: control two, value, direction
  reg  [7:0]  a_ctl2_q;
  reg  [7:0]  a_val_q;
  reg  [7:0]  a_dir_q;
  reg  [7:0]  b_ctl2_q;
  reg  [7:0]  b_val_q;
  reg  [7:0]  b_dir_q;
  reg  [7:0]  c_ctl2_q;
  reg  [7:0]  c_val_q;
  reg  [7:0]  c_dir_q;
  // port d: two function selects, value, direction
  reg  [7:0]  d_fn1_q;
  reg  [7:0]  d_fn2_q;
  reg  [7:0]  d_val_q;
  reg  [7:0]  d_dir_q;
  // system configuration
  reg  [7:0]  cfg0_q;
  reg  [7:0]  cfg1_q;
  // pin synchroniser stages
  reg  [31:0] pin_meta_q;
  reg  [31:0] pin_sync_q;
  // next values of the registered outputs
  reg  [31:0] pin_out_d;
  reg  [31:0] pin_oe_d;
  reg  [7:0]  rd_d;

  // one store per request: ack high blocks a repeated write
  wire [15:0] idx = wb_adr_i >> 2;
  wire        wr  = wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0] & ~wb_ack_o;

  // ==========================================================
  // pin synchroniser
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_meta_q <= 32'h00000000;
      pin_sync_q <= 32'h00000000;
    end else begin
      pin_meta_q <= pin_in_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ==========================================================
  // port a registers; reset leaves all pins as inputs in microcomputer mode
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      a_ctl2_q <= `RST_REG8;
      a_val_q  <= `RST_REG8;
      a_dir_q  <= `RST_REG8;
    end else if (wr) begin
      case (idx)
        `IDX_A_CTL2: a_ctl2_q <= wb_dat_i[7:0]; // R12
        `IDX_A_VAL:  a_val_q  <= wb_dat_i[7:0];
        `IDX_A_DIR:  a_dir_q  <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // port b registers
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      b_ctl2_q <= `RST_REG8;
      b_val_q  <= `RST_REG8;
      b_dir_q  <= `RST_REG8;
    end else if (wr) begin
      case (idx)
        `IDX_B_CTL2: b_ctl2_q <= wb_dat_i[7:0]; // R13
        `IDX_B_VAL:  b_val_q  <= wb_dat_i[7:0];
        `IDX_B_DIR:  b_dir_q  <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // port c registers
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      c_ctl2_q <= `RST_REG8;
      c_val_q  <= `RST_REG8;
      c_dir_q  <= `RST_REG8;
    end else if (wr) begin
      case (idx)
        `IDX_C_CTL2: c_ctl2_q <= wb_dat_i[7:0]; // R14
        `IDX_C_VAL:  c_val_q  <= wb_dat_i[7:0];
        `IDX_C_DIR:  c_dir_q  <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // port d registers; selects stay off until software sets them
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      d_fn1_q <= `RST_REG8;
      d_fn2_q <= `RST_REG8;
      d_val_q <= `RST_REG8;
      d_dir_q <= `RST_REG8;
    end else if (wr) begin
      case (idx)
        `IDX_D_FN1: d_fn1_q <= wb_dat_i[7:0];
        `IDX_D_FN2: d_fn2_q <= wb_dat_i[7:0]; // R19
        `IDX_D_VAL: d_val_q <= wb_dat_i[7:0];
        `IDX_D_DIR: d_dir_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // system configuration; bit four clear after reset
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg0_q <= `RST_REG8;
      cfg1_q <= `RST_REG8; // R15
    end else if (wr) begin
      case (idx)
        `IDX_SYS_CFG0: cfg0_q <= wb_dat_i[7:0];
        `IDX_SYS_CFG1: cfg1_q <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // address decode of the current external cycle
  wire in_eprom  = (ext_addr_i >= `EPROM_LO);                          // R2
  wire in_ram    = (ext_addr_i >= `RAM_LO) && (ext_addr_i <= `RAM_HI); // R3
  wire in_periph = (ext_addr_i >= `PERIPH_LO) &&
                   (ext_addr_i <= `PERIPH_HI);                         // R4

  // one bank per type wins by fixed priority, so only one select fires
  wire e1 = d_fn2_q[`D_EPROM1_BIT];
  wire e2 = d_fn2_q[`D_EPROM2_BIT] & ~e1;
  wire e3 = d_fn2_q[`D_EPROM3_BIT] & ~e1 & ~d_fn2_q[`D_EPROM2_BIT]; // R1
  wire r1 = d_fn2_q[`D_RAM1_BIT];
  wire r2 = d_fn2_q[`D_RAM2_BIT] & ~r1;                             // R1

  // active-low selects, high outside a mapped cycle
  wire cs_e1 = ~(ext_cycle_i & in_eprom & e1);  // R23
  wire cs_e2 = ~(ext_cycle_i & in_eprom & e2);  // R23
  wire cs_e3 = ~(ext_cycle_i & in_eprom & e3);  // R23
  wire cs_r1 = ~(ext_cycle_i & in_ram & r1);    // R23
  wire cs_r2 = ~(ext_cycle_i & in_ram & r2);    // R23
  wire cs_pf = ~(ext_cycle_i & in_periph);      // R23
  wire strobe_n = ~ext_cycle_i;

  // ==========================================================
  // per-pin function choice
  integer i;
  reg [7:0] fa_d, fb_d;
  reg       fen_d;
  always @* begin
    pin_out_d = 32'h00000000;
    pin_oe_d  = 32'h00000000;
    fa_d      = 8'h00;
    fb_d      = 8'h00;
    fen_d     = 1'b0;
    // port a: data bus drives on writes only
    for (i = 0; i < 8; i = i + 1) begin
      if (a_ctl2_q[i] | micro_proc_mode_i) begin                        // R9
        pin_out_d[i] = ext_wdata_i[i];
        pin_oe_d[i]  = ext_cycle_i & ext_write_i;                       // R12
      end else begin
        pin_out_d[i] = a_val_q[i];                                      // R8
        pin_oe_d[i]  = a_dir_q[i];                                      // R7
      end
    end
    // ports b and c: address bus
    for (i = 0; i < 8; i = i + 1) begin
      if (b_ctl2_q[i] | micro_proc_mode_i) begin                        // R13
        pin_out_d[8+i] = ext_addr_i[i];
        pin_oe_d[8+i]  = 1'b1;
      end else begin
        pin_out_d[8+i] = b_val_q[i];
        pin_oe_d[8+i]  = b_dir_q[i];
      end
      if (c_ctl2_q[i] | micro_proc_mode_i) begin                        // R14
        pin_out_d[16+i] = ext_addr_i[8+i];
        pin_oe_d[16+i]  = 1'b1;
      end else begin
        pin_out_d[16+i] = c_val_q[i];
        pin_oe_d[16+i]  = c_dir_q[i];
      end
    end
    // port d: function a and b signals
    // function a: bit 0 ram bank 2 select
    //             bit 1 eprom bank 3 select
    //             bit 2 eprom bank 2 select
    //             bit 3 clock out
    //             bit 4 read/write, low on writes
    //             bit 5 peripheral select
    //             bit 6 eprom bank 1 select
    //             bit 7 ram bank 1 select
    // function b: bit 0 low, bit 6 access strobe, bit 7 high
    // pins 1 2 5 have no function b and stay general i/o
    // a select pin that is not a function shows its value bit,
    // so a preset one keeps the bank deselected
    fa_d = {cs_r1, cs_e1, cs_pf, ~ext_write_i, clkout_i, cs_e2, cs_e3, cs_r2};
    fb_d = {1'b1, strobe_n, 1'b1, ~ext_write_i, clkout_i, 1'b1, 1'b1, 1'b0};
    for (i = 0; i < 8; i = i + 1) begin
      fen_d = 1'b0;
      if (micro_proc_mode_i) begin
        // no selects; d1 d2 d5 stay general purpose
        fen_d = (i != 1) && (i != 2) && (i != 5);                       // R5 R11
        pin_out_d[24+i] = fen_d ? fb_d[i] : d_val_q[i];
      end else if (d_fn2_q[i]) begin
        fen_d = (d_fn1_q[i] == 1'b0) || ((i != 1) && (i != 2) && (i != 5));
        pin_out_d[24+i] = d_fn1_q[i] ? fb_d[i] : fa_d[i];               // R9
      end else begin
        pin_out_d[24+i] = d_val_q[i];                                   // R17
      end
      // pins 1 2 5 in function b fall back to general i/o
      if (!fen_d) begin
        pin_out_d[24+i] = d_val_q[i];                                   // R8
      end
      pin_oe_d[24+i] = fen_d ? 1'b1 : d_dir_q[i];                       // R7 R17
    end
  end

  // ==========================================================
  // register read mux; value registers read pin level
  always @* begin
    case (idx)
      `IDX_A_CTL2:   rd_d = a_ctl2_q;
      `IDX_A_VAL:    rd_d = pin_sync_q[7:0];     // R7
      `IDX_A_DIR:    rd_d = a_dir_q;
      `IDX_B_CTL2:   rd_d = b_ctl2_q;
      `IDX_B_VAL:    rd_d = pin_sync_q[15:8];
      `IDX_B_DIR:    rd_d = b_dir_q;
      `IDX_C_CTL2:   rd_d = c_ctl2_q;
      `IDX_C_VAL:    rd_d = pin_sync_q[23:16];
      `IDX_C_DIR:    rd_d = c_dir_q;
      `IDX_D_FN1:    rd_d = d_fn1_q;
      `IDX_D_FN2:    rd_d = d_fn2_q;
      `IDX_D_VAL:    rd_d = pin_sync_q[31:24];
      `IDX_D_DIR:    rd_d = d_dir_q;
      `IDX_SYS_CFG0: rd_d = cfg0_q;
      `IDX_SYS_CFG1: rd_d = cfg1_q;
      default:       rd_d = 8'h00;
    endcase
  end

  // ==========================================================
  // bus answer: one-cycle ack with read data beside it
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= {24'h000000, rd_d};
    end
  end

  // ==========================================================
  // registered pins; reset releases every pin
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pin_out_o <= 32'h00000000;
      pin_oe_o  <= 32'h00000000;
    end else begin
      pin_out_o <= pin_out_d;
      pin_oe_o  <= pin_oe_d;
    end
  end

  // ==========================================================
  // outputs to the core
  always @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_rdata_o     <= 8'h00;
      wait_enable_o   <= 1'b1;
      boot_internal_o <= 1'b1;                        // R16
    end else begin
      ext_rdata_o     <= pin_sync_q[7:0];
      wait_enable_o   <= ~cfg1_q[`CFG1_WAIT_BIT];     // R15
      boot_internal_o <= 1'b1;                        // R16
    end
  end

endmodule

/* verification/port_mux_bank_select_properties.sv */
// assertions on the port multiplexer and bank selects
// assumes binding to the top module, seeing only its ports
module port_mux_props (
  // clock, reset, bus
  input wire        sys_clk_i,
  input wire        rstn_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  // external cycle and pins
  input wire        ext_cycle_i,
  input wire        ext_write_i,
  input wire [15:0] ext_addr_i,
  input wire        micro_proc_mode_i,
  input wire [31:0] pin_out_o,
  input wire [31:0] pin_oe_o,
  input wire        boot_internal_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========================
  // handshake and pins
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_BOOT: assert property (boot_internal_o)
    else $error("boot not internal");
  AST_EPROM_ONE: assert property ($past(ext_cycle_i && !micro_proc_mode_i && ext_addr_i[15])
    |-> $countones(~{pin_out_o[30], pin_out_o[26:25]}) < 2) else $error("two eprom selects");
  AST_RAM_FALL: assert property ($fell(pin_out_o[31]) && !micro_proc_mode_i
    |-> $past(ext_cycle_i && ext_addr_i[15:13] == 3'h1)) else $error("ram select stray");
  AST_PERIPH_FALL: assert property ($fell(pin_out_o[29]) && !micro_proc_mode_i
    |-> $past(ext_cycle_i && ext_addr_i[15:6] == 10'h043)) else $error("periph select stray");
  AST_ADDR: assert property (micro_proc_mode_i && ext_cycle_i
    |=> pin_out_o[23:8] == $past(ext_addr_i) && pin_oe_o[23:8] == 16'hffff)
    else $error("address pins wrong");
  AST_DATA_OFF: assert property (micro_proc_mode_i && !(ext_cycle_i && ext_write_i)
    |=> pin_oe_o[7:0] == 8'h00) else $error("data bus driven");
endmodule
bind port_mux_bank_select port_mux_props u_props (.sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .ext_cycle_i, .ext_write_i, .ext_addr_i, .micro_proc_mode_i, .pin_out_o,
  .pin_oe_o, .boot_internal_o);

/* verification/bank_memories.sv */
// model of the eprom, ram and peripheral banks on the data bus
// assumes active-low selects on port d, data back on port a
module bank_memories (
  // clock and selects
  input  wire        sys_clk_i,
  input  wire  [7:0] sel_n_i,
  input  wire        rd_i,
  // data bus level
  output logic [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last_q = 8'h00;
  logic       drv;
  // a selected bank answers with its select pattern
  assign drv = rd_i && ((sel_n_i & 8'he7) != 8'he7);
  // a released bus shows the inverse of the last byte
  assign data_o = drv ? (~sel_n_i & 8'he7) : ~last_q;
  // remember the last driven byte
  always @(posedge sys_clk_i) begin
    if (drv) last_q <= data_o;
  end
endmodule

/* verification/tb_top.sv */
// bench for the port multiplexer and bank selects
// assumes the bank model on port a and pulled-up port d pins
`include "port_mux_map.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = '0, rstn = '0, cyc = '0, stb = '0, we = '0, ext = '0, ewr = '0, micro = '0;
  logic [15:0] adr = '0, ea = '0;
  logic [31:0] wdat = '0;
  logic [7:0]  ewd = '0, d_lvl = 8'hff;
  wire  [31:0] rdat, pout, poe;
  wire  [7:0]  erd, mem_d;
  wire         ack, wen, boot;
  int          bad_count = 0, n_tests = 0;
  logic [31:0] cases [11] = '{32'hd0800040, 32'hd0200080, 32'h03ffff02, 32'h033fff01,
    32'h04800004, 32'h2010c020, 32'h2010ff20, 32'h2010bf00, 32'h20110000, 32'hd0400000,
    32'h037fff00};
  logic [23:0] init [8] = '{24'h1021ff, 24'h1025ff, 24'h10297f, 24'h102b00, 24'h102c00,
    24'h102ee7, 24'h102dd0, 24'h102fe7};
  // ==========================
  // design and bank model
  port_mux_bank_select i_dut (.sys_clk_i(clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .ext_cycle_i(ext), .ext_write_i(ewr), .ext_addr_i(ea), .ext_wdata_i(ewd),
    .clkout_i(1'b0), .micro_proc_mode_i(micro), .pin_in_i({d_lvl, 16'h0000, mem_d}),
    .pin_out_o(pout), .pin_oe_o(poe), .ext_rdata_o(erd), .wait_enable_o(wen),
    .boot_internal_o(boot));
  bank_memories i_mem (.sys_clk_i(clk), .sel_n_i(pout[31:24]), .rd_i(ext && !ewr),
    .data_o(mem_d));
  // clock and hang limit
  initial begin
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle, held until ack
  task automatic wb(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a[13:0], 2'b00, 24'h0, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, q, {24'h0, e});
  endtask
  // external cycle held for six clocks
  task automatic xc(input logic w, input logic [15:0] a);
    @(posedge clk);
    {ext, ewr, ea} <= {1'b1, w, a};
    repeat (6) @(posedge clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================
  // tests
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    chk("wait", wen, 1'b1);
    chk("boot", boot, 1'b1);
    chk("oe", poe, 32'h0);
    rd(`IDX_A_CTL2, 8'h00, "reset value");
    rd(16'h1030, 8'h00, "unmapped");
    wr(`IDX_SYS_CFG1, 8'h10);
    repeat (2) @(posedge clk);
    chk("wait off", wen, 1'b0);
    wr(`IDX_SYS_CFG1, 8'h10 & 8'hef);
    repeat (2) @(posedge clk);
    chk("wait on", wen, 1'b1);
    $display("test reset done");
    foreach (init[i]) wr(init[i][23:8], init[i][7:0]);
    repeat (2) @(posedge clk);
    chk("addr oe", poe[23:0], 24'h7fff00);
    ewd <= 8'h5a;
    xc(1'b1, 16'h21a5);
    chk("write bus", {poe[7:0], pout[7:0]}, 16'hff5a);
    chk("address", pout[22:8], 15'h21a5);
    ext <= 1'b0;
    $display("test setup done");
    foreach (cases[i]) begin
      wr(`IDX_D_FN2, cases[i][31:24]);
      xc(1'b0, cases[i][23:8]);
      chk("selects", pout[31:24] & 8'he7, 8'he7 & ~cases[i][7:0]);
      if (cases[i][7:0] != 8'h00) chk("bank data", erd, cases[i][7:0]);
      ext <= 1'b0;
    end
    $display("test banks done");
    wr(`IDX_D_FN2, 8'h00);
    wr(`IDX_D_VAL, 8'he5);
    repeat (2) @(posedge clk);
    chk("gpio out", {poe[31:24], pout[31:24]}, 16'he7e5);
    wr(`IDX_D_DIR, 8'h00);
    d_lvl <= 8'h3c;
    repeat (4) @(posedge clk);
    rd(`IDX_D_VAL, 8'h3c, "gpio in");
    chk("gpio oe", poe[31:24], 8'h00);
    $display("test gpio done");
    wr(`IDX_D_FN2, 8'h26);
    micro <= 1'b1;
    xc(1'b0, 16'h8123);
    chk("micro addr", pout[23:8], 16'h8123);
    chk("micro gpio", {pout[29], pout[26]}, 2'b11);
    ext <= 1'b0;
    $display("test micro done");
    complete_run();
  end
endmodule
